// file: dhar_regs.vh
// register offsets, report layout and fixed values for the attribute report block
// assumes apb with 32-bit data, byte addresses, one register per aligned word
`ifndef DHAR_REGS_VH
`define DHAR_REGS_VH
// register byte offsets
`define DHAR_CMD_ADDR      12'h000
`define DHAR_STAT_ADDR     12'h004
`define DHAR_OFFL_ADDR     12'h008
`define DHAR_TEST_ADDR     12'h00c
`define DHAR_TIME_ADDR     12'h010
`define DHAR_DUR_ADDR      12'h014
`define DHAR_ATTR_ADDR     12'h018
`define DHAR_DATA_ADDR     12'h01c
// command codes written to the command register
`define DHAR_SUB_AUTO      8'hdb
`define DHAR_SUB_READ      8'hd0
// sector count codes
`define DHAR_SC_DISABLE    8'h00
`define DHAR_SC_ENABLE     8'hf8
// report layout
`define DHAR_REV           16'h0010
`define DHAR_ENT_BASE      9'h002
`define DHAR_ENT_LAST      9'h15e
`define DHAR_ENT_LEN       4'hc
`define DHAR_ENT_NUM       5'h1e
`define DHAR_OFF_OFFL      9'h16a
`define DHAR_OFF_TEST      9'h16b
`define DHAR_OFF_TIME      9'h16c
`define DHAR_OFF_OCAP      9'h16f
`define DHAR_OFF_SCAP      9'h170
`define DHAR_OFF_ELOG      9'h172
`define DHAR_OFF_CHKP      9'h173
`define DHAR_OFF_SHORT     9'h174
`define DHAR_OFF_EXT       9'h175
`define DHAR_OFF_EXTW      9'h177
`define DHAR_OFF_SUM       9'h1ff
// fixed capability values
`define DHAR_OCAP          8'h1b
`define DHAR_SCAP          16'h0003
`define DHAR_ELOG          8'h01
`define DHAR_EXT_BIG       8'hff
// normalized value limits
`define DHAR_NORM_MIN      8'h01
`define DHAR_NORM_MAX      8'hfd
`endif

// file: dhar_report.v
// attribute report block: automatic off-line control and 512-byte report streaming
// assumes an apb master on pclk; firmware loads attribute table and status words
// assumes zero-wait apb; one data register read hands out one report byte
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "dhar_regs.vh"

// What this block does
// - sector count zero disables automatic collection
// - code f8 enables automatic collection
// - other codes keep setting, flag abort
// - disabling never blocks attribute saving
// - report streamed whole, 512 bytes
// - multi-byte fields emitted least byte first
// - revision 0010 at offset zero
// - thirty twelve-byte entries from offset 02
// - entry id, flags, value, vendor bytes
// - zero id means unused entry
// - only supported ids appear active
// - flag bit0 prefail, bits 6-15 zero
// - flag bit1 marks on-line update
// - raw counts converted to normalized values
// - status byte bit7 shows auto enable
// - status low bits use defined codes
// - self-test remaining limited zero to nine
// - self-test status codes in upper nibble
// - collection seconds word at 16c
// - fixed capability values 1b, 0003, 01
// - checkpoint at 173, short time 174
// - extended byte ff above fe, word at 177
// - last byte makes byte sum zero
module dhar_report
  (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        auto_offline_en,
  output wire        save_allowed
  );

  // apb access strobes
  wire        wr_en;                // write in access phase
  wire        rd_en;                // read in access phase
  // command and status state
  reg         auto_en;              // automatic off-line enable
  reg         abort_flag;           // sticky aborted-command flag
  reg  [6:0]  offl_code;            // off-line status code
  reg  [3:0]  test_left;            // self-test remaining tenths
  reg  [3:0]  test_code;            // self-test status code
  reg  [15:0] offl_secs;            // seconds to complete collection
  reg  [7:0]  chk_point;            // self-test failure checkpoint
  reg  [7:0]  short_min;            // short self-test minutes
  reg  [15:0] ext_min;              // extended self-test minutes
  // attribute table, one 32-bit word per entry
  reg  [31:0] attr_tab [0:29];      // id, flags bits, raw value, vendor byte
  // report streaming
  reg         busy;                 // report being streamed
  reg  [8:0]  idx;                  // next byte offset
  reg  [7:0]  sum;                  // running byte sum
  wire [7:0]  cur_byte;             // byte at idx
  wire [7:0]  strm_byte;            // byte with checksum substituted
  // decoded transfers
  wire        cmd_wr;               // command register written
  wire        auto_cmd;             // automatic off-line control subcommand
  wire        start_rd;             // read-attribute-values subcommand
  wire        data_rd;              // data register read, one report byte
  // entry position within the report
  wire [8:0]  rel;                  // offset from first entry
  wire [8:0]  ent_q;                // full quotient, entry number
  wire [8:0]  ent_r;                // full remainder, byte in entry
  wire [4:0]  ent_no;               // entry number 0..29
  wire [3:0]  ent_k;                // byte 0..11 inside the entry
  wire        in_ent;               // offset lies in the entry area
  integer     i;                    // reset loop index

  // constants that are sliced need a named home
  localparam [15:0] REV_WORD  = `DHAR_REV;                 // structure revision
  localparam [15:0] SCAP_WORD = `DHAR_SCAP;                // capability word
  localparam [8:0]  ENT_LEN   = {5'h00, `DHAR_ENT_LEN};    // bytes per entry

  // access phase strobes; the transfer is taken on this edge
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  // zero wait states and no bus error: refused sector count codes are flagged in status
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  // command and data register decodes
  assign cmd_wr   = wr_en & (paddr == `DHAR_CMD_ADDR);
  assign auto_cmd = cmd_wr & (pwdata[7:0] == `DHAR_SUB_AUTO);
  assign start_rd = cmd_wr & (pwdata[7:0] == `DHAR_SUB_READ);
  // a data read only advances while a report is open
  assign data_rd  = rd_en & (paddr == `DHAR_DATA_ADDR) & busy;
  assign auto_offline_en = auto_en;
  assign save_allowed = 1'b1;

  // supported identifier check
  function id_ok;
    input [7:0] id;
    begin
      // unlisted ids, zero among them, read unused
      // supported list only
      case (id)
        8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09,
        8'h0a, 8'h0c, 8'h16, 8'hc0, 8'hc1, 8'hc2, 8'hc4, 8'hc5,
        8'hc6, 8'hc7: id_ok = 1'b1;
        default: id_ok = 1'b0;
      endcase
    end
  endfunction

  // normalize raw count: value limited to 01..fd
  function [7:0] norm;
    input [7:0] raw;
    begin
      // raw counts outside the range pin to a limit
      // clamp into compare range
      if (raw < `DHAR_NORM_MIN)
        norm = `DHAR_NORM_MIN;
      else if (raw > `DHAR_NORM_MAX)
        norm = `DHAR_NORM_MAX;
      else
        norm = raw;
    end
  endfunction

  // collection status codes that firmware may post
  function offl_ok;
    input [6:0] code;
    begin
      // never started, done, suspended, aborted, fatal
      case (code)
        7'h00, 7'h02, 7'h04, 7'h05, 7'h06: offl_ok = 1'b1;
        default: offl_ok = 1'b0;
      endcase
    end
  endfunction

  // one byte of an attribute entry
  function [7:0] ent_byte;
    input [31:0] w;
    input [3:0]  k;
    begin
      // unused or unsupported entry reads zero
      if (!id_ok(w[31:24]))
        ent_byte = 8'h00;
      else
        case (k)
          4'h0: ent_byte = w[31:24];
          // bit0 prefail, bit1 online, upper zero
          4'h1: ent_byte = {6'h00, w[17:16]};
          // flag bits 8-15 reserved
          4'h2: ent_byte = 8'h00;
          // normalized value
          4'h3: ent_byte = norm(w[15:8]);
          // first vendor byte, the rest read zero
          4'h4: ent_byte = w[7:0];
          default: ent_byte = 8'h00;
        endcase
    end
  endfunction

  // entry number and byte within entry; division kept at full width, then cut
  assign rel    = idx - `DHAR_ENT_BASE;
  assign ent_q  = rel / ENT_LEN;
  assign ent_r  = rel - (ent_q * ENT_LEN);
  // only the low bits matter inside the entry area
  assign ent_no = ent_q[4:0];
  assign ent_k  = ent_r[3:0];
  // entries fill 02h up to the status byte
  assign in_ent = (idx >= `DHAR_ENT_BASE) && (idx < `DHAR_OFF_OFFL);

  assign cur_byte =
    (idx == 9'h000) ? REV_WORD[7:0] :
    (idx == 9'h001) ? REV_WORD[15:8] :
    in_ent ? ent_byte(attr_tab[ent_no], ent_k) :
    (idx == `DHAR_OFF_OFFL) ? {auto_en, offl_code} :
    (idx == `DHAR_OFF_TEST) ? {test_code, test_left} :
    (idx == `DHAR_OFF_TIME) ? offl_secs[7:0] :
    (idx == `DHAR_OFF_TIME + 9'h001) ? offl_secs[15:8] :
    (idx == `DHAR_OFF_OCAP) ? `DHAR_OCAP :
    (idx == `DHAR_OFF_SCAP) ? SCAP_WORD[7:0] :
    (idx == `DHAR_OFF_SCAP + 9'h001) ? SCAP_WORD[15:8] :
    (idx == `DHAR_OFF_ELOG) ? `DHAR_ELOG :
    (idx == `DHAR_OFF_CHKP) ? chk_point :
    (idx == `DHAR_OFF_SHORT) ? short_min :
    (idx == `DHAR_OFF_EXT) ? ((ext_min > 16'h00fe) ? `DHAR_EXT_BIG : ext_min[7:0]) :
    (idx == `DHAR_OFF_EXTW) ? ext_min[7:0] :
    (idx == `DHAR_OFF_EXTW + 9'd1) ? ext_min[15:8] :
    8'h00;

  assign strm_byte = (idx == `DHAR_OFF_SUM) ? (8'h00 - sum) : cur_byte;

  // register writes and command handling
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // collection off, no status posted
      auto_en    <= 1'b0;
      abort_flag <= 1'b0;
      offl_code  <= 7'h00;
      test_left  <= 4'h0;
      test_code  <= 4'h0;
      offl_secs  <= 16'h0000;
      chk_point  <= 8'h00;
      short_min  <= 8'h00;
      ext_min    <= 16'h0000;
      // attribute table empty: every entry reads unused
      for (i = 0; i < 30; i = i + 1)
        attr_tab[i] <= 32'h00000000;
    end
    else
    begin
      // host and firmware writes, one per access phase
      if (wr_en)
      begin
        case (paddr)
          // command: [15:8] sector count, [7:0] subcommand
          `DHAR_CMD_ADDR:
          begin
            if (auto_cmd)
            begin
              if (pwdata[15:8] == `DHAR_SC_DISABLE)
                auto_en <= 1'b0;
              else if (pwdata[15:8] == `DHAR_SC_ENABLE)
                auto_en <= 1'b1;
              else
                abort_flag <= 1'b1;
            end
            // the read subcommand is taken by the streaming process
          end
          // status: write one clears abort flag
          `DHAR_STAT_ADDR:
            if (pwdata[1])
              abort_flag <= 1'b0;
          `DHAR_OFFL_ADDR:
            if (offl_ok(pwdata[6:0]))
              offl_code <= pwdata[6:0];
            // any other code keeps the last one posted
          // remaining limited 0..9
          `DHAR_TEST_ADDR:
          begin
            test_left <= (pwdata[3:0] > 4'h9) ? 4'h9 : pwdata[3:0];
            test_code <= pwdata[7:4];
            chk_point <= pwdata[15:8];
          end
          // seconds for one collection pass
          `DHAR_TIME_ADDR:
            offl_secs <= pwdata[15:0];
          // self-test durations in minutes
          `DHAR_DUR_ADDR:
          begin
            short_min <= pwdata[7:0];
            ext_min   <= pwdata[31:16];
          end
          // attribute load: [28:24] entry, [31:30] flags, low 24 bits id/raw/vendor
          `DHAR_ATTR_ADDR:
            if (pwdata[28:24] < `DHAR_ENT_NUM)
              attr_tab[pwdata[28:24]] <= {pwdata[23:16], 6'h00, pwdata[31:30],
                                          pwdata[15:8], pwdata[7:0]};
          // read-only and unmapped words ignore writes
          default: ;
        endcase
      end
    end
  end

  // report streaming: a read subcommand rewinds, each data read takes one byte
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      idx  <= 9'h000;
      sum  <= 8'h00;
    end
    else if (start_rd)
    begin
      // restart whole report from offset zero
      busy <= 1'b1;
      idx  <= 9'h000;
      sum  <= 8'h00;
    end
    else if (data_rd)
    begin
      // running sum of every byte handed out
      sum <= sum + strm_byte;
      // stream ends only after byte 511
      if (idx == `DHAR_OFF_SUM)
        busy <= 1'b0;
      // offset wraps to zero after the checksum byte
      idx <= idx + 9'h001;
    end
  end

  // read data mux, registered
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    // setup cycle of a read: data stands through the access phase
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        // busy, abort flag, automatic enable
        `DHAR_STAT_ADDR: prdata <= {29'h0, busy, abort_flag, auto_en};
        // same byte the report carries at 16ah
        `DHAR_OFFL_ADDR: prdata <= {24'h0, auto_en, offl_code};
        // checkpoint, status nibble, remaining tenths
        `DHAR_TEST_ADDR: prdata <= {16'h0, chk_point, test_code, test_left};
        `DHAR_TIME_ADDR: prdata <= {16'h0, offl_secs};
        `DHAR_DUR_ADDR:  prdata <= {ext_min, 8'h00, short_min};
        // report byte at the current offset, offset low bits for debug
        `DHAR_DATA_ADDR: prdata <= {15'h0, busy, 1'b0, idx[6:0], strm_byte};
        // command, attribute and unmapped words read zero
        default:         prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// file: dhar_host.sv
// apb host model issuing subcommands to the report block
// assumes xfer is called just after a rising pclk edge
`timescale 1ns/1ps
module dhar_host
  (
  input  wire         pclk,
  input  wire         pready,
  input  wire  [31:0] prdata,
  output logic        psel = 1'b0,
  output logic        penable = 1'b0,
  output logic        pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0
  );
  int gap = 1;  // idle cycles after a transfer
  int hung = 0; // no answer within bound
  task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 64);
    hung = n > 63;
    q = prdata;
    penable <= 1'b0;
    // a released bus shows inverted lines
    if (gap > 0)
    begin
      psel <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      repeat (gap) @(posedge pclk);
    end
  endtask
endmodule

// file: dhar_monitor.sv
// port checker for the report block, bound below
// assumes one report byte per read of the data register
`timescale 1ns/1ps
`include "dhar_regs.vh"
module dhar_monitor
  (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        auto_offline_en,
  input wire        save_allowed
  );
  wire       wr = psel & penable & pwrite;                          // write taken
  wire       rd = psel & penable & !pwrite & paddr == `DHAR_DATA_ADDR; // byte read
  wire       cm = wr & paddr == `DHAR_CMD_ADDR;                     // command write
  wire       au = cm & pwdata[7:0] == `DHAR_SUB_AUTO;              // auto control
  wire [7:0] sc = pwdata[15:8];                                     // sector count
  reg  [9:0] pos;                                                   // offset, 200h idle
  reg  [7:0] sum;                                                   // running sum
  // follow the report stream
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pos <= 10'h200;
      sum <= 8'h00;
    end
    else if (cm & pwdata[7:0] == `DHAR_SUB_READ)
    begin
      pos <= 10'h000;
      sum <= 8'h00;
    end
    else if (rd & !pos[9])
    begin
      pos <= pos + 10'h001;
      sum <= sum + prdata[7:0];
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_auto_off: assert property (au & sc == 8'h00 |=> !auto_offline_en)
    else $error("auto still on");
  a_auto_on: assert property (au & sc == 8'hf8 |=> auto_offline_en)
    else $error("auto still off");
  a_auto_keep: assert property (au & sc != 8'h00 & sc != 8'hf8 |=> $stable(auto_offline_en))
    else $error("auto changed");
  a_save_kept: assert property (!auto_offline_en |-> save_allowed)
    else $error("saving blocked");
  a_block_busy: assert property (rd |-> prdata[16] == !pos[9])
    else $error("busy wrong");
  a_auto_byte: assert property (rd && pos == 10'h16a |-> prdata[7] == auto_offline_en)
    else $error("auto bit wrong");
  a_rev_byte: assert property (rd && pos == 10'h000 |-> prdata[7:0] == 8'h10)
    else $error("revision wrong");
  a_cap_byte: assert property (rd && pos == 10'h16f |-> prdata[7:0] == 8'h1b)
    else $error("capability wrong");
  a_sum_zero: assert property (rd && pos == 10'h1ff |-> sum + prdata[7:0] == 8'h00)
    else $error("checksum wrong");
  c_on: cover property (au & sc == 8'hf8);
  c_keep: cover property (au & sc == 8'h05);
  c_end: cover property (rd && pos == 10'h1ff);
endmodule
bind dhar_report dhar_monitor dhar_monitor_i
  (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .auto_offline_en(auto_offline_en), .save_allowed(save_allowed));

// file: testbench.sv
// self-checking bench for the report block
// assumes the host model and the bound checker
`timescale 1ns/1ps
`include "dhar_regs.vh"
module testbench;
  logic        pclk = 1'b0;    // 200 mhz clock
  logic        presetn = 1'b0; // reset, active low
  wire         psel, penable, pwrite, pready, pslverr, auto_offline_en, save_allowed;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata;
  logic [31:0] q, v;           // read data, random word
  int          failures, check_count, seed, aen, i, e, s, x, id, raw;
  int          m [512];        // expected report bytes
  int          sup [18] = '{1, 2, 3, 4, 5, 7, 8, 9, 10, 12, 22, 192, 193, 194, 196, 197, 198, 199};
  int          cod [7] = '{8'hf8, 5, 0, 8'hff, 8'hf8, 1, 0};
  int          ofl [5] = '{0, 2, 4, 5, 6};
  dhar_host dhar_host_i (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  dhar_report dhar_report_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .auto_offline_en(auto_offline_en), .save_allowed(save_allowed));
  initial
    forever #2.5 pclk = ~pclk;
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    check_count++;
    if (got !== want)
    begin
      failures++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  // one bus transfer, a hang ends the run
  task automatic acc(input bit w, input logic [11:0] a, input logic [31:0] d);
    dhar_host_i.xfer(w, a, d, q);
    if (dhar_host_i.hung)
    begin
      failures++;
      print_verdict();
    end
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    seed = 32'h9ecf;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // sector count codes, vendor ones included
    for (i = 0; i < 8; i++)
    begin
      s = (i == 7) ? ($random(seed) & 8'hff) : cod[i];
      acc(1'b1, `DHAR_CMD_ADDR, {16'h0, s[7:0], `DHAR_SUB_AUTO});
      aen = (s == 0) ? 0 : (s == 8'hf8) ? 1 : aen;
      acc(1'b0, `DHAR_STAT_ADDR, 32'h0);
      chk(q[1:0], {s != 0 && s != 8'hf8, aen[0]}, "status");
      chk(auto_offline_en, aen, "auto pin");
      chk(save_allowed, 1, "save");
      chk(pslverr, 0, "bus error");
      acc(1'b1, `DHAR_STAT_ADDR, 32'h2);
    end
    acc(1'b0, 12'h0fc, 32'h0);
    chk(q, 0, "unmapped");
    // one full report per collection status code
    for (s = 0; s < 5; s++)
    begin
      aen = s & 1;
      m = '{default: 0};
      acc(1'b1, `DHAR_CMD_ADDR, aen ? 32'hf8db : 32'h00db);
      acc(1'b1, `DHAR_OFFL_ADDR, ofl[s]);
      acc(1'b1, `DHAR_OFFL_ADDR, 32'h3); // refused code keeps the old one
      v = $random(seed);
      acc(1'b1, `DHAR_TEST_ADDR, {16'h0, v[15:0]});
      m[0] = 8'h10;
      m[9'h16a] = aen * 128 + ofl[s];
      m[9'h16b] = v[7:4] * 16 + (v[3:0] > 9 ? 9 : v[3:0]);
      m[9'h173] = v[15:8];
      v = $random(seed);
      x = s * 128 + 8'h7e; // straddles the one-byte duration limit
      acc(1'b1, `DHAR_TIME_ADDR, {16'h0, v[15:0]});
      acc(1'b1, `DHAR_DUR_ADDR, {x[15:0], 8'h0, v[23:16]});
      m[9'h16c] = v[7:0];
      m[9'h16d] = v[15:8];
      m[9'h16f] = 8'h1b;
      m[9'h170] = 3;
      m[9'h172] = 1;
      m[9'h174] = v[23:16];
      m[9'h175] = x > 8'hfe ? 8'hff : x;
      m[9'h177] = x & 8'hff;
      m[9'h178] = x >> 8;
      // entries with clamp boundaries and stray ids
      for (e = 0; e < 30; e++)
      begin
        v = $random(seed);
        id = (e < 18) ? sup[e] : v[15:8];
        raw = (e == s) ? 0 : (e == s + 1) ? 8'hff : v[7:0];
        acc(1'b1, `DHAR_ATTR_ADDR, {v[31:30], 1'b0, e[4:0], id[7:0], raw[7:0], v[23:16]});
        if (id inside {sup})
        begin
          m[2 + 12 * e] = id;
          m[3 + 12 * e] = v[31] * 2 + v[30];
          m[5 + 12 * e] = raw < 1 ? 1 : raw > 8'hfd ? 8'hfd : raw;
          m[6 + 12 * e] = v[23:16];
        end
      end
      for (i = 0; i < 511; i++)
        m[511] -= m[i];
      m[511] &= 8'hff;
      acc(1'b1, `DHAR_CMD_ADDR, 32'hd0);
      // stream back to back, then one read past the end
      for (i = 0; i < 513; i++)
      begin
        dhar_host_i.gap = (i == 512);
        acc(1'b0, `DHAR_DATA_ADDR, 32'h0);
        chk(q[16], i < 512, "busy");
        if (i < 9'h16a)
          chk(q[7:0], m[i], "entry");
        else if (i < 512)
          chk(q[7:0], m[i], "tail");
      end
    end
    print_verdict();
  end
endmodule
